// ---- core/cds_pkg.sv ----
// package: constants, types and decode helpers for the complement/decrement/skip execution block
package cds_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 5;
   localparam int INSTR_W = 12;
   // field positions inside the 12-bit instruction word
   localparam int OPC_MSB = 11;
   localparam int OPC_LSB = 6;
   localparam int DEST_POS = 5;
   localparam int ADDR_MSB = 4;
   // six-bit opcode prefixes
   localparam logic [5:0] OPC_INVERT = 6'h09; // 0010 01
   localparam logic [5:0] OPC_MINUS = 6'h03; // 0000 11
   localparam logic [5:0] OPC_MINUS_SKIP = 6'h0B; // 0010 11
   // destination select
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   // reset values and the decrement step
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic ZERO_RST = 1'b0;
   localparam logic [4:0] ADDR_RST = 5'h00;
   localparam logic [7:0] DATA_ONE = 8'h01;

   typedef enum logic [1:0] {
      CDS_OP_PASS = 2'h0,
      CDS_OP_INV = 2'h1,
      CDS_OP_DEC = 2'h2
   } cds_op_e;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_DISCARD = 2'b10
   } cds_state_e;

   function automatic logic [5:0] cds_opc(input logic [11:0] instr);
      return instr[OPC_MSB:OPC_LSB];
   endfunction : cds_opc

   function automatic logic cds_known(input logic [11:0] instr);
      logic [5:0] o;
      o = cds_opc(instr);
      return (o == OPC_INVERT) || (o == OPC_MINUS) || (o == OPC_MINUS_SKIP);
   endfunction : cds_known
endpackage : cds_pkg

// ---- core/cds_alu_if.sv ----
// interface: operation request and result between executor and its arithmetic unit
`timescale 1ns/10ps
interface cds_alu_if;
   import cds_pkg::*;
   cds_op_e op;
   logic [7:0] operand;
   logic [7:0] result;
   logic zero;
   modport exec (output op, output operand, input result, input zero);
   modport alu (input op, input operand, output result, output zero);
endinterface : cds_alu_if

// ---- core/cds_alu.sv ----
// module: combinational invert/decrement unit with zero detect
`timescale 1ns/10ps
module cds_alu
   import cds_pkg::*;
(
   cds_alu_if.alu alu
);
   // result and zero detect, purely combinational
   always_comb begin
      unique case (alu.op)
         CDS_OP_INV: alu.result = ~alu.operand;
         CDS_OP_DEC: alu.result = alu.operand - DATA_ONE;
         default: alu.result = alu.operand;
      endcase
      alu.zero = (alu.result == 8'h00);
   end
endmodule : cds_alu

// ---- core/cds_exec.sv ----
// module: execution of the invert, decrement and decrement-skip file instructions
`timescale 1ns/10ps
// Summary of operation
// - invert: all eight bits of the selected register inverted, zero flag from result
// - destination bit 0 writes the accumulator, 1 writes back the file register
// - opcode 0000 11 d fffff: register minus one, zero flag updated
// - opcode 0010 11 d fffff: register minus one, status left unchanged
// - decrement-skip with zero result discards the next instruction, runs an idle cycle
module cds_exec
   import cds_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic instr_valid_in,
   input wire logic [11:0] instr_in,
   input wire logic [7:0] file_rdata_in,
   output logic [7:0] acc_out,
   output logic zero_flag_out,
   output logic file_we_out,
   output logic [4:0] file_addr_out,
   output logic [7:0] file_wdata_out,
   output logic done_out,
   output logic skip_out,
   output logic idle_out
);
   logic rst_meta_q;
   logic rst_n_q;
   cds_state_e state_q, state_d;
   logic [7:0] acc_q, acc_d;
   logic zero_q, zero_d;
   logic we_q, we_d;
   logic [4:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d;
   logic done_q, done_d;
   logic skip_q, skip_d;
   logic idle_q, idle_d;
   logic [5:0] opc;
   logic dest;
   logic [4:0] sel;
   logic hit;
   cds_alu_if alu_if ();

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   cds_alu u_alu (
      .alu (alu_if.alu)
   );

   // field decode and operand select; a write issued last cycle has not yet reached
   // the file, so its data is forwarded to avoid a stale read
   always_comb begin
      opc = cds_opc(instr_in);
      dest = instr_in[DEST_POS];
      sel = instr_in[ADDR_MSB:0];
      hit = instr_valid_in && (state_q == ST_RUN) && cds_known(instr_in);
      if (we_q && (addr_q == sel)) begin
         alu_if.operand = wdata_q;
      end else begin
         alu_if.operand = file_rdata_in;
      end
      unique case (opc)
         OPC_INVERT: alu_if.op = CDS_OP_INV;
         OPC_MINUS: alu_if.op = CDS_OP_DEC;
         OPC_MINUS_SKIP: alu_if.op = CDS_OP_DEC;
         default: alu_if.op = CDS_OP_PASS;
      endcase
   end

   // next-state: one instruction per cycle, one idle cycle after a taken skip
   always_comb begin
      state_d = state_q;
      acc_d = acc_q;
      zero_d = zero_q;
      we_d = 1'b0;
      addr_d = addr_q;
      wdata_d = wdata_q;
      done_d = 1'b0;
      skip_d = 1'b0;
      idle_d = 1'b0;
      unique case (state_q)
         ST_RUN: begin
            if (hit) begin
               done_d = 1'b1;
               if (dest == DEST_ACC) begin
                  acc_d = alu_if.result;
               end else begin
                  we_d = 1'b1;
                  addr_d = sel;
                  wdata_d = alu_if.result;
               end
               if (opc != OPC_MINUS_SKIP) begin
                  zero_d = alu_if.zero;
               end
               if ((opc == OPC_MINUS_SKIP) && alu_if.zero) begin
                  skip_d = 1'b1;
                  state_d = ST_DISCARD;
               end
            end
         end
         ST_DISCARD: begin
            // the fetched word is dropped; waits for it if fetch stalled
            if (instr_valid_in) begin
               idle_d = 1'b1;
               state_d = ST_RUN;
            end
         end
      endcase
   end

   // registers only
   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_RUN;
         acc_q <= ACC_RST;
         zero_q <= ZERO_RST;
         we_q <= 1'b0;
         addr_q <= ADDR_RST;
         wdata_q <= ACC_RST;
         done_q <= 1'b0;
         skip_q <= 1'b0;
         idle_q <= 1'b0;
      end else begin
         state_q <= state_d;
         acc_q <= acc_d;
         zero_q <= zero_d;
         we_q <= we_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         done_q <= done_d;
         skip_q <= skip_d;
         idle_q <= idle_d;
      end
   end

   assign acc_out = acc_q;
   assign zero_flag_out = zero_q;
   assign file_we_out = we_q;
   assign file_addr_out = addr_q;
   assign file_wdata_out = wdata_q;
   assign done_out = done_q;
   assign skip_out = skip_q;
   assign idle_out = idle_q;

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_q);

   a_invert_value: assert property (
      hit && (opc == OPC_INVERT) && (dest == DEST_ACC)
      |=> (acc_out == ~$past(alu_if.operand))
          && (zero_flag_out == (~$past(alu_if.operand) == 8'h00)))
      else $error("invert result or zero flag wrong");

   a_invert_file: assert property (
      hit && (opc == OPC_INVERT) && (dest == DEST_FILE)
      |=> (file_wdata_out == ~$past(alu_if.operand))
          && (zero_flag_out == (~$past(alu_if.operand) == 8'h00)))
      else $error("invert written to the file wrong");

   a_dest_route: assert property (
      hit && (dest == DEST_FILE)
      |=> file_we_out && (file_addr_out == $past(sel)) && $stable(acc_out))
      else $error("file destination not honoured");

   a_dest_acc: assert property (
      hit && (dest == DEST_ACC) |=> !file_we_out)
      else $error("accumulator destination wrote the file");

   a_minus_value: assert property (
      hit && (opc == OPC_MINUS) && (dest == DEST_FILE)
      |=> (file_wdata_out == $past(alu_if.operand) - DATA_ONE)
          && (zero_flag_out == ($past(alu_if.operand) == DATA_ONE)))
      else $error("decrement result or zero flag wrong");

   a_minus_acc: assert property (
      hit && (opc == OPC_MINUS) && (dest == DEST_ACC)
      |=> (acc_out == $past(alu_if.operand) - DATA_ONE)
          && (zero_flag_out == ($past(alu_if.operand) == DATA_ONE)))
      else $error("decrement into the accumulator wrong");

   a_skip_value: assert property (
      hit && (opc == OPC_MINUS_SKIP) && (dest == DEST_FILE)
      |=> file_we_out && (file_wdata_out == $past(alu_if.operand) - DATA_ONE))
      else $error("decrement-skip result wrong");

   a_skip_status: assert property (
      hit && (opc == OPC_MINUS_SKIP) |=> $stable(zero_flag_out))
      else $error("decrement-skip touched the zero flag");

   // a taken skip parks the block in the discard state; a fetch stall there has no bound,
   // so the idle cycle is checked from the word that finally arrives
   a_skip_taken: assert property (
      hit && (opc == OPC_MINUS_SKIP) && (alu_if.operand == DATA_ONE)
      |=> skip_out && (state_q == ST_DISCARD))
      else $error("zero decrement-skip did not enter the discard state");

   a_skip_idle: assert property (
      (state_q == ST_DISCARD) && instr_valid_in
      |=> idle_out && !done_out && !file_we_out && $stable(acc_out) && $stable(zero_flag_out))
      else $error("skipped word not replaced by an idle cycle");

   a_skip_not_taken: assert property (
      hit && (opc == OPC_MINUS_SKIP) && (alu_if.operand != DATA_ONE) |=> !skip_out)
      else $error("skip taken on a nonzero result");

   a_invert_single: assert property (
      hit && (opc == OPC_INVERT) |=> done_out && !skip_out)
      else $error("invert not completed in one cycle");

   // words of other instructions belong to other units and must leave this block untouched
   a_ignore_unknown: assert property (
      instr_valid_in && (state_q == ST_RUN) && !cds_known(instr_in)
      |=> !done_out && !file_we_out && $stable(acc_out) && $stable(zero_flag_out))
      else $error("unknown word changed the block state");

   c_skip_idle: cover property (skip_out ##[1:4] idle_out);
   c_invert_file: cover property (hit && (opc == OPC_INVERT) && (dest == DEST_FILE));
   c_minus_zero: cover property (hit && (opc == OPC_MINUS) && alu_if.zero);
   c_forward: cover property (hit && we_q && (addr_q == sel));
endmodule : cds_exec

// ---- dv/test_complement_decrement_skip_exec.sv ----
// testbench: directed and random invert/decrement/skip words checked through a queue of notes
`timescale 1ns/10ps
module test_complement_decrement_skip_exec;
   import cds_pkg::*;
   typedef struct {logic idle; logic [7:0] acc; logic z; logic we; logic skip; logic [4:0] a;
      logic [7:0] w; int t;} cds_exp_s;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic instr_valid_in = 1'b0;
   logic [11:0] instr_in = 12'h000;
   logic [7:0] file_rdata_in, acc_out, file_wdata_out;
   logic zero_flag_out, file_we_out, done_out, skip_out, idle_out;
   logic [4:0] file_addr_out;
   logic [7:0] mem [32];
   logic [7:0] file_m [32];
   logic [7:0] acc_m = 8'h00;
   logic z_m = 1'b0;
   logic skip_m = 1'b0;
   cds_exp_s exp_q [$];
   int error_cnt = 0;
   int cmp_count = 0;
   int ncnt = 0;
   int cyc = 0;

   always #2.5 clk_in = ~clk_in;
   // register file beside the block: read is combinational, write lands at the pulse's edge
   assign file_rdata_in = mem[instr_in[4:0]];
   always @(posedge clk_in) if (file_we_out === 1'b1) mem[file_addr_out] <= file_wdata_out;

   cds_exec dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .instr_valid_in(instr_valid_in),
      .instr_in(instr_in), .file_rdata_in(file_rdata_in), .acc_out(acc_out),
      .zero_flag_out(zero_flag_out), .file_we_out(file_we_out), .file_addr_out(file_addr_out),
      .file_wdata_out(file_wdata_out), .done_out(done_out), .skip_out(skip_out),
      .idle_out(idle_out));

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic idle_gap;
      @(posedge clk_in);
      instr_valid_in <= 1'b0;
   endtask : idle_gap

   // drive one word and note what must appear from the edge that takes it, one cycle after the edge that drives it
   task automatic issue(input logic [11:0] ins);
      cds_exp_s e;
      logic [5:0] op;
      logic [7:0] r;
      @(posedge clk_in);
      instr_valid_in <= 1'b1;
      instr_in <= ins;
      op = ins[11:6];
      r = (op == OPC_INVERT) ? ~file_m[ins[4:0]] : file_m[ins[4:0]] - 8'h01;
      e = '{1'b0, acc_m, z_m, ins[5], 1'b0, ins[4:0], r, ncnt + 2};
      if (skip_m) begin
         // any opcode in the slot after a zero skip is dropped
         skip_m = 1'b0;
         e.idle = 1'b1;
         exp_q.push_back(e);
      end else if (op == OPC_INVERT || op == OPC_MINUS || op == OPC_MINUS_SKIP) begin
         if (ins[5] == DEST_ACC) acc_m = r;
         else file_m[ins[4:0]] = r;
         if (op != OPC_MINUS_SKIP) z_m = (r == 8'h00);
         skip_m = (op == OPC_MINUS_SKIP) && (r == 8'h00);
         e.acc = acc_m;
         e.z = z_m;
         e.skip = skip_m;
         exp_q.push_back(e);
      end
   endtask : issue

   // watcher: every pulse takes the oldest note and is compared field by field
   always @(negedge clk_in) begin
      cds_exp_s e;
      ncnt++;
      if (done_out === 1'b1 || idle_out === 1'b1) begin
         if (exp_q.size() == 0) chk("stray pulse", 16'h0000, 16'h0001);
         else begin
            e = exp_q.pop_front();
            chk("latency", 16'(e.t), 16'(ncnt));
            chk("done idle", {14'h0, ~e.idle, e.idle}, {14'h0, done_out, idle_out});
            if (!e.idle) begin
               chk("acc z skip", {e.acc, e.z, e.skip, 6'h0},
                  {acc_out, zero_flag_out, skip_out, 6'h0});
               chk("file we", {15'h0, e.we}, {15'h0, file_we_out});
               if (e.we) begin
                  chk("write", {3'h0, e.a, e.w}, {3'h0, file_addr_out, file_wdata_out});
               end
            end else begin
               // a dropped word must leave accumulator, flag and file alone
               chk("idle quiet", {e.acc, e.z, 7'h0},
                  {acc_out, zero_flag_out, file_we_out, skip_out, 5'h0});
            end
         end
      end
   end

   // hang guard, far above the few hundred cycles the sequence needs
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   initial begin
      logic [11:0] ins;
      logic [5:0] ops [4];
      ops = '{OPC_INVERT, OPC_MINUS, OPC_MINUS_SKIP, 6'h0A};
      void'($urandom(78217));
      for (int i = 0; i < 32; i++) mem[i] = (i < 3) ? 8'(i) : 8'($urandom);
      mem[19] = 8'h13;
      file_m = mem;
      repeat (5) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      issue(12'h253);
      issue({OPC_MINUS, DEST_FILE, 5'h01});
      issue({OPC_MINUS_SKIP, DEST_FILE, 5'h02});
      issue({OPC_MINUS_SKIP, DEST_ACC, 5'h02});
      issue(12'h253);
      issue({OPC_MINUS_SKIP, DEST_FILE, 5'h02});
      idle_gap();
      issue(12'hA83);
      issue(12'hA83);
      issue({OPC_INVERT, DEST_FILE, 5'h01});
      // only registers 0 to 7, so repeated decrements reach zero and skips fire often
      for (int k = 0; k < 400; k++) begin
         ins = {ops[$urandom % 4], 1'($urandom), 5'($urandom % 8)};
         issue(ins);
         if ($urandom % 4 == 0) idle_gap();
      end
      idle_gap();
      issue(12'hA83);
      idle_gap();
      repeat (3) @(posedge clk_in);
      chk("notes left", 16'h0000, 16'(exp_q.size()));
      print_verdict();
   end
endmodule : test_complement_decrement_skip_exec
